// ===== asm_pkg.sv
package asm_pkg;

  // I/O addresses of the extension registers
  localparam logic [7:0] ASM_ADDR_EXT_CTRL0 = 8'h12;
  localparam logic [7:0] ASM_ADDR_EXT_CTRL1 = 8'h13;
  localparam logic [7:0] ASM_ADDR_DIV0_LO   = 8'h1A;
  localparam logic [7:0] ASM_ADDR_DIV0_HI   = 8'h1B;
  localparam logic [7:0] ASM_ADDR_DIV1_LO   = 8'h1C;
  localparam logic [7:0] ASM_ADDR_DIV1_HI   = 8'h1D;

  // Extension control field positions
  localparam int ASM_BIT_RX_INT_EN   = 7;
  localparam int ASM_BIT_DCD_ADVISE  = 6;
  localparam int ASM_BIT_CTS_ADVISE  = 5;
  localparam int ASM_BIT_X1_CLOCK    = 4;
  localparam int ASM_BIT_BAUD_CNT16  = 3;
  localparam int ASM_BIT_BRK_ENABLE  = 2;
  localparam int ASM_BIT_BRK_DETECT  = 1;
  localparam int ASM_BIT_SEND_BREAK  = 0;

  // Values after reset
  localparam logic [7:0]  ASM_RST_EXT_CTRL = 8'h00;
  localparam logic [15:0] ASM_RST_DIVISOR  = 16'h0000;
  localparam logic [7:0]  ASM_RST_RDATA    = 8'h00;
  // Channel 1 reserved bits 6..5 read and store as zero
  localparam logic [7:0]  ASM_CTRL1_WMASK  = 8'h9D;
  localparam logic [7:0]  ASM_CTRL0_WMASK  = 8'hFD;

  // Sampling-rate dividers
  localparam int         ASM_SMP_W     = 6;
  localparam logic [5:0] ASM_SMP_LAST16 = 6'h0F;
  localparam logic [5:0] ASM_SMP_LAST64 = 6'h3F;
  localparam logic [5:0] ASM_SMP_ZERO   = 6'h00;

  typedef struct packed {
    logic [1:0][7:0]          ctrl;
    logic [1:0][15:0]         divisor;
    logic                     dcd_hold;
    logic [1:0]               brk;
    logic [1:0]               ext_q;
    logic [1:0][ASM_SMP_W-1:0] smp_cnt;
    logic [1:0]               tick;
    logic [1:0]               tx_low;
    logic                     rts;
    logic [7:0]               rdata;
  } asm_state_s;

endpackage

// ===== asm_ext.sv
`timescale 1ns/1ps
// Function
// - Bit 7 zero inhibits receive interrupt
// - Channel 0 bit 6 makes carrier-detect advisory
// - Bit 4 direct bit clock; bit 3 16-bit counter
// - Bit 2 break enable, 1 detect, 0 sends
// - Two 8-bit divisor halves per channel, reset zero
// - Clear-to-send high forces transmit-empty flag low unless channel 0 bit 5 set
// - Clear-to-send never stops transmission in progress
// - Carrier-detect high forces receive-full flag low
// - Carrier-detect high also forces error flags low
// - Flags stay forced until status read after fall
// - First read after fall still shows carrier high
// - Request-to-send is plain output, no side effects
// - Channel 1 clear-to-send gates when selected
// - Registers take reset values during reset
// - Serial activity halts during reset
// - Reset leaves holding registers untouched
// - External clock feeds sampling divider directly
module asm_ext #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // I/O register port
  input  wire logic [ADDR_W-1:0] io_addr,
  input  wire logic              io_wr,
  input  wire logic              io_rd,
  input  wire logic [7:0]        io_wdata,
  output      logic [7:0]        io_rdata,
  // Base channel state and status-read strobe
  input  wire logic [1:0]        tx_empty_raw,
  input  wire logic [1:0]        rx_full_raw,
  input  wire logic              parity_error_raw0,
  input  wire logic              framing_error_raw0,
  input  wire logic              overrun_raw0,
  input  wire logic              status_reg0_rd,
  input  wire logic              chan1_cts_select,
  input  wire logic              request_to_send_ctrl,
  // Gated flags toward status registers and interrupt logic
  output      logic [1:0]        tx_empty_flag,
  output      logic [1:0]        rx_full_flag,
  output      logic              parity_error_flag0,
  output      logic              framing_error_flag0,
  output      logic              overrun_flag0,
  output      logic              status0_dcd_bit,
  output      logic [1:0]        rx_int_req,
  // Modem lines
  input  wire logic              clear_to_send_in0,
  input  wire logic              carrier_detect_in0,
  input  wire logic              clocked_serial_rx,
  output      logic              request_to_send_out0,
  // Clocking toward the baud stage
  input  wire logic              chan0_ext_clock_pin,
  input  wire logic              chan1_ext_clock_pin,
  input  wire logic [1:0]        ext_clock_sel,
  input  wire logic [1:0]        sample_div64,
  input  wire logic [1:0]        prescale_tick,
  output      logic [1:0]        bit_tick,
  output      logic [1:0]        baud_counter_mode,
  output      logic [15:0]       divisor0,
  output      logic [15:0]       divisor1,
  // Serial lines and break
  input  wire logic [1:0]        tx_serial_raw,
  input  wire logic [1:0]        rx_serial_in,
  input  wire logic [1:0]        rx_break_seen,
  output      logic [1:0]        tx_serial_out
);
  import asm_pkg::*;

  if (ADDR_W < 8) begin : g_addr_chk
    $error("ADDR_W must be at least 8");
  end

  asm_state_s st_r;
  asm_state_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Modem gating

  logic       dcd_gate;
  logic       clear_to_send_in0_gate;
  logic       clear_to_send_in1_gate;
  logic [7:0] addr8;

  assign addr8 = io_addr[7:0];

  // Held until the status read after the carrier falls
  assign dcd_gate  = !st_r.ctrl[0][ASM_BIT_DCD_ADVISE]
                     && (carrier_detect_in0 || st_r.dcd_hold);
  assign clear_to_send_in0_gate = !st_r.ctrl[0][ASM_BIT_CTS_ADVISE] && clear_to_send_in0;
  // Shared pin only counts as clear-to-send when selected
  assign clear_to_send_in1_gate = chan1_cts_select && clocked_serial_rx;

  // Only the flag is masked; the transmitter keeps shifting
  assign tx_empty_flag[0] = tx_empty_raw[0] && !clear_to_send_in0_gate;
  assign tx_empty_flag[1] = tx_empty_raw[1] && !clear_to_send_in1_gate;
  assign rx_full_flag[0]  = rx_full_raw[0] && !dcd_gate;
  assign rx_full_flag[1]  = rx_full_raw[1];
  assign parity_error_flag0  = parity_error_raw0 && !dcd_gate;
  assign framing_error_flag0 = framing_error_raw0 && !dcd_gate;
  assign overrun_flag0       = overrun_raw0 && !dcd_gate;
  // Stays 1 on the first read after the fall
  assign status0_dcd_bit = carrier_detect_in0 || st_r.dcd_hold;

  assign request_to_send_out0 = st_r.rts;
  assign divisor0             = st_r.divisor[0];
  assign divisor1             = st_r.divisor[1];
  assign io_rdata             = st_r.rdata;
  assign bit_tick             = st_r.tick;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel clock path

  logic [1:0] ext_pin;
  logic [1:0] ext_edge;
  logic [1:0] src_tick;
  logic [1:0] direct_clk;
  logic [1:0] smp_wrap;

  assign ext_pin = {chan1_ext_clock_pin, chan0_ext_clock_pin};

  for (genvar i = 0; i < 2; i++) begin : g_chan
    assign ext_edge[i]   = ext_pin[i] && !st_r.ext_q[i];
    // External clock skips the prescaler entirely
    assign src_tick[i]   = ext_clock_sel[i] ? ext_edge[i] : prescale_tick[i];
    assign direct_clk[i] = st_r.ctrl[i][ASM_BIT_X1_CLOCK] && ext_clock_sel[i];
    assign smp_wrap[i]   = st_r.smp_cnt[i] == (sample_div64[i] ? ASM_SMP_LAST64
                                                               : ASM_SMP_LAST16);
    assign rx_int_req[i] = rx_full_flag[i] && st_r.ctrl[i][ASM_BIT_RX_INT_EN];
    assign baud_counter_mode[i] = st_r.ctrl[i][ASM_BIT_BAUD_CNT16];
    // Idle mark while reset holds the flop
    assign tx_serial_out[i] = !st_r.tx_low[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    // Set wins over the clearing read
    if (carrier_detect_in0) begin
      st_nxt.dcd_hold = 1'b1;
    end else if (status_reg0_rd) begin
      st_nxt.dcd_hold = 1'b0;
    end
    // Software level only; touches nothing else
    st_nxt.rts = request_to_send_ctrl;
    for (int i = 0; i < 2; i++) begin
      st_nxt.ext_q[i] = ext_pin[i];
      st_nxt.tick[i]  = 1'b0;
      if (direct_clk[i]) begin
        st_nxt.tick[i]    = ext_edge[i];
        st_nxt.smp_cnt[i] = ASM_SMP_ZERO;
      end else if (src_tick[i]) begin
        st_nxt.tick[i]    = smp_wrap[i];
        st_nxt.smp_cnt[i] = smp_wrap[i] ? ASM_SMP_ZERO
                                        : st_r.smp_cnt[i] + 6'h01;
      end
      // Detect holds until the line returns to mark or break enable is cleared
      if (rx_break_seen[i] && st_r.ctrl[i][ASM_BIT_BRK_ENABLE]) begin
        st_nxt.brk[i] = 1'b1;
      end else if (rx_serial_in[i] || !st_r.ctrl[i][ASM_BIT_BRK_ENABLE]) begin
        st_nxt.brk[i] = 1'b0;
      end
      st_nxt.tx_low[i] = st_r.ctrl[i][ASM_BIT_SEND_BREAK] || !tx_serial_raw[i];
    end
    // Register writes; detect bit is read-only
    if (io_wr) begin
      case (addr8)
        ASM_ADDR_EXT_CTRL0: st_nxt.ctrl[0] = io_wdata & ASM_CTRL0_WMASK;
        ASM_ADDR_EXT_CTRL1: st_nxt.ctrl[1] = io_wdata & ASM_CTRL1_WMASK;
        ASM_ADDR_DIV0_LO:   st_nxt.divisor[0][7:0]  = io_wdata;
        ASM_ADDR_DIV0_HI:   st_nxt.divisor[0][15:8] = io_wdata;
        ASM_ADDR_DIV1_LO:   st_nxt.divisor[1][7:0]  = io_wdata;
        ASM_ADDR_DIV1_HI:   st_nxt.divisor[1][15:8] = io_wdata;
        default: ;
      endcase
    end
    if (io_rd) begin
      case (addr8)
        ASM_ADDR_EXT_CTRL0: st_nxt.rdata = st_r.ctrl[0] | {6'h00, st_r.brk[0], 1'b0};
        ASM_ADDR_EXT_CTRL1: st_nxt.rdata = st_r.ctrl[1] | {6'h00, st_r.brk[1], 1'b0};
        ASM_ADDR_DIV0_LO:   st_nxt.rdata = st_r.divisor[0][7:0];
        ASM_ADDR_DIV0_HI:   st_nxt.rdata = st_r.divisor[0][15:8];
        ASM_ADDR_DIV1_LO:   st_nxt.rdata = st_r.divisor[1][7:0];
        ASM_ADDR_DIV1_HI:   st_nxt.rdata = st_r.divisor[1][15:8];
        default:            st_nxt.rdata = ASM_RST_RDATA;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  // Holding registers live outside and see no reset here

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r         <= '0;
      st_r.ctrl    <= {ASM_RST_EXT_CTRL, ASM_RST_EXT_CTRL};
      st_r.divisor <= {ASM_RST_DIVISOR, ASM_RST_DIVISOR};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_dcd_read_low;
    ce && status_reg0_rd && !carrier_detect_in0;
  endsequence

  sequence s_still_low;
    ce && !carrier_detect_in0;
  endsequence

  AST_RX_INHIBIT: assert property (rx_int_req[0] |-> st_r.ctrl[0][7])
    else $error("receive interrupt raised while inhibited");
  AST_DCD_GATE: assert property (!st_r.ctrl[0][6] && carrier_detect_in0
                                 |-> !rx_full_flag[0])
    else $error("receive-full seen with carrier high");
  AST_ERR_GATE: assert property (!st_r.ctrl[0][6] && carrier_detect_in0
                                 |-> !(parity_error_flag0 || framing_error_flag0
                                       || overrun_flag0))
    else $error("error flag seen with carrier high");
  AST_DCD_REARM: assert property (ce && $fell(carrier_detect_in0) && !status_reg0_rd
                                  && !st_r.ctrl[0][6] |-> !rx_full_flag[0]
                                  && status0_dcd_bit)
    else $error("flags released before status read");
  AST_DCD_TWICE: assert property (s_dcd_read_low ##1 s_still_low
                                  |-> !status0_dcd_bit)
    else $error("carrier bit still set on second read");
  AST_CLEAR_TO_SEND_IN0_MASK: assert property (!st_r.ctrl[0][5] && clear_to_send_in0
                                  |-> !tx_empty_flag[0])
    else $error("transmit-empty seen with clear-to-send high");
  AST_CTS_ADVISE: assert property (st_r.ctrl[0][5] |-> tx_empty_flag[0] == tx_empty_raw[0])
    else $error("advisory clear-to-send still gated");
  AST_CLEAR_TO_SEND_IN1_MASK: assert property (chan1_cts_select && clocked_serial_rx
                                  |-> !tx_empty_flag[1])
    else $error("channel 1 transmit-empty not gated");
  AST_SEND_BREAK: assert property (ce && st_r.ctrl[0][0] |=> !tx_serial_out[0])
    else $error("send break did not drive the line low");
  AST_RSVD_ZERO: assert property (st_r.ctrl[1][6:5] == 2'b00)
    else $error("reserved channel 1 bits not zero");
  AST_RTS_PORT: assert property (ce |=> request_to_send_out0
                                 == $past(request_to_send_ctrl))
    else $error("request-to-send does not follow software");
  AST_BRK_HOLD: assert property (ce && st_r.brk[0] && !rx_serial_in[0]
                                 && st_r.ctrl[0][2] |=> st_r.brk[0])
    else $error("break detect dropped while line low");
  AST_X1_CLOCK: assert property (ce && direct_clk[0] && ext_edge[0] |=> bit_tick[0])
    else $error("direct external clock edge gave no tick");

  ////////////////////////////////////////////////////////////////////////////
  // Register port and gating checks

  sequence s_carrier_high;
    ce && carrier_detect_in0;
  endsequence

  sequence s_ctrl0_write;
    ce && io_wr && addr8 == ASM_ADDR_EXT_CTRL0;
  endsequence

  AST_RX_INHIBIT1: assert property (rx_int_req[1] |-> st_r.ctrl[1][7])
    else $error("channel 1 receive interrupt raised while inhibited");

  AST_RX_ADVISE: assert property (st_r.ctrl[0][6] |->
                                  rx_full_flag[0] == rx_full_raw[0])
    else $error("advisory carrier still gates receive-full");

  AST_ERR_ADVISE: assert property (st_r.ctrl[0][6] |->
                                   parity_error_flag0 == parity_error_raw0)
    else $error("advisory carrier still gates parity error");

  AST_CTS_FREE: assert property (!clear_to_send_in0 |->
                                 tx_empty_flag[0] == tx_empty_raw[0])
    else $error("transmit-empty masked with clear-to-send low");

  AST_CLEAR_TO_SEND_IN1_OFF: assert property (!chan1_cts_select |->
                                 tx_empty_flag[1] == tx_empty_raw[1])
    else $error("channel 1 transmit-empty masked while not selected");

  AST_TX_FOLLOW: assert property (ce && !st_r.ctrl[0][0] |=>
                                  tx_serial_out[0] == $past(tx_serial_raw[0]))
    else $error("serial output stopped following the transmitter");

  AST_BAUD_MODE: assert property (s_ctrl0_write |=>
                                  baud_counter_mode[0] == $past(io_wdata[3]))
    else $error("baud counter mode did not take the written bit");

  AST_X1_WRITE: assert property (s_ctrl0_write |=>
                                 st_r.ctrl[0][4] == $past(io_wdata[4]))
    else $error("bit clock select did not take the written bit");

  AST_DET_RO: assert property (s_ctrl0_write |=> !st_r.ctrl[0][1])
    else $error("break detect bit was written");

  AST_DIV0_LO: assert property (ce && io_wr && addr8 == ASM_ADDR_DIV0_LO |=>
                                divisor0[7:0] == $past(io_wdata))
    else $error("divisor 0 low byte not written");

  AST_DIV1_HI: assert property (ce && io_wr && addr8 == ASM_ADDR_DIV1_HI |=>
                                divisor1[15:8] == $past(io_wdata))
    else $error("divisor 1 high byte not written");

  AST_RD_DIV0: assert property (ce && io_rd && addr8 == ASM_ADDR_DIV0_LO |=>
                                io_rdata == $past(divisor0[7:0]))
    else $error("divisor 0 low byte read back wrong");

  AST_RSVD_READ: assert property (ce && io_rd && addr8 == ASM_ADDR_EXT_CTRL1 |=>
                                  io_rdata[6:5] == 2'b00)
    else $error("reserved channel 1 bits read as one");

  AST_BRK_READ: assert property (ce && io_rd && addr8 == ASM_ADDR_EXT_CTRL0
                                 && st_r.brk[0] |=> io_rdata[1])
    else $error("break detect not shown on read");

  AST_BRK_SET: assert property (ce && rx_break_seen[0] && st_r.ctrl[0][2]
                                |=> st_r.brk[0])
    else $error("break detect not set");

  AST_BRK_CLEAR: assert property (ce && !rx_break_seen[0] && rx_serial_in[0]
                                  |=> !st_r.brk[0])
    else $error("break detect kept after line returned to mark");

  AST_DCD_SHOW: assert property (s_carrier_high |=> status0_dcd_bit)
    else $error("carrier bit lost right after carrier high");

  AST_DCD_RELEASE: assert property (s_dcd_read_low |=> !st_r.dcd_hold)
    else $error("carrier hold kept after status read");

endmodule

// ===== asm_peer.sv
`timescale 1ns/1ps
// Far-side modem model: levels follow bench commands, clock pin pulses on request
module asm_peer (
  // Clock
  input  wire logic       clk,
  // Commands from the bench
  input  wire logic       cts_cmd,
  input  wire logic       dcd_cmd,
  input  wire logic       srx_cmd,
  input  wire logic [1:0] line_cmd,
  input  wire logic       pulse_cmd,
  // Modem side lines
  output      logic       cts,
  output      logic       dcd,
  output      logic       srx,
  output      logic [1:0] rx_line,
  output      logic       ext_pin
);
  assign cts     = cts_cmd;
  assign dcd     = dcd_cmd;
  assign srx     = srx_cmd;
  // Idle receive lines rest at mark level
  assign rx_line = line_cmd;
  initial ext_pin = 1'h0;
  // One high cycle per request, so each request is a fresh rising edge
  always @(posedge clk) begin
    ext_pin <= pulse_cmd & ~ext_pin;
  end
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import asm_pkg::*;
  logic       clk = 1'h0, rst_n = 1'h0, io_wr = 1'h0, io_rd = 1'h0, st_rd = 1'h0;
  logic       c1_sel = 1'h0, rts_ctrl = 1'h0, err_raw = 1'h0;
  logic       cts_cmd = 1'h0, dcd_cmd = 1'h0, srx_cmd = 1'h0, pulse_cmd = 1'h0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00;
  logic [1:0] tx_raw = 2'h3, rx_raw = 2'h3, tx_e_raw = 2'h3, brk_seen = 2'h0;
  logic [1:0] line_cmd = 2'h3, ext_sel = 2'h0;
  logic [7:0] io_rdata;
  logic [1:0] tx_e, rx_f, irq, tick, bmode, tx_out, rx_line;
  logic       par_err, frm_err, ov, dcd_bit, rts_out, cts, dcd, srx, ext_pin;
  logic [15:0] div0, div1;
  logic [7:0] adr [6] = '{8'h12, 8'h13, 8'h1A, 8'h1B, 8'h1C, 8'h1D};
  logic [7:0] val [4] = '{8'h5A, 8'hC3, 8'h3C, 8'h96};
  int         n_errors = 0, comparisons = 0, ticks = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (tick[0] === 1'h1) ticks++;

  asm_peer asm_peer_i (.clk(clk), .cts_cmd(cts_cmd), .dcd_cmd(dcd_cmd), .srx_cmd(srx_cmd),
    .line_cmd(line_cmd), .pulse_cmd(pulse_cmd), .cts(cts), .dcd(dcd), .srx(srx),
    .rx_line(rx_line), .ext_pin(ext_pin));

  asm_ext asm_ext_i (.clk(clk), .rst_n(rst_n), .ce(1'h1), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .tx_empty_raw(tx_e_raw),
    .rx_full_raw(rx_raw), .parity_error_raw0(err_raw), .framing_error_raw0(err_raw),
    .overrun_raw0(err_raw), .status_reg0_rd(st_rd), .chan1_cts_select(c1_sel),
    .request_to_send_ctrl(rts_ctrl), .tx_empty_flag(tx_e), .rx_full_flag(rx_f),
    .parity_error_flag0(par_err), .framing_error_flag0(frm_err), .overrun_flag0(ov),
    .status0_dcd_bit(dcd_bit), .rx_int_req(irq), .clear_to_send_in0(cts),
    .carrier_detect_in0(dcd), .clocked_serial_rx(srx), .request_to_send_out0(rts_out),
    .chan0_ext_clock_pin(ext_pin), .chan1_ext_clock_pin(1'h0), .ext_clock_sel(ext_sel),
    .sample_div64(2'h0), .prescale_tick(2'h0), .bit_tick(tick), .baud_counter_mode(bmode),
    .divisor0(div0), .divisor1(div1), .tx_serial_raw(tx_raw), .rx_serial_in(rx_line),
    .rx_break_seen(brk_seen), .tx_serial_out(tx_out));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'h1;
    @(negedge clk);
    io_wr = 1'h0;
  endtask

  // Read data is registered, so it is looked at one cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'h1;
    @(negedge clk);
    io_rd = 1'h0;
    check(io_rdata, exp);
  endtask

  task automatic pulse();
    @(negedge clk);
    pulse_cmd = 1'h1;
    cyc(2);
    pulse_cmd = 1'h0;
  endtask

  task automatic finish_test();
    $display("Errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(5);
    check({tx_out, rts_out, tick}, 16'h0018);
    rst_n = 1'h1;
    for (int i = 0; i < 6; i++) rd(adr[i], 8'h00);
    rd(8'h14, 8'h00);
    wr(ASM_ADDR_EXT_CTRL0, 8'hFF);
    rd(ASM_ADDR_EXT_CTRL0, 8'hFD);
    wr(ASM_ADDR_EXT_CTRL1, 8'hFF);
    rd(ASM_ADDR_EXT_CTRL1, 8'h9D);
    check(bmode, 16'h0003);
    for (int i = 0; i < 4; i++) wr(adr[i+2], val[i]);
    for (int i = 0; i < 4; i++) rd(adr[i+2], val[i]);
    check(div1, 16'h963C);
    check(div0, 16'hC35A);
    wr(ASM_ADDR_EXT_CTRL0, 8'h00);
    wr(ASM_ADDR_EXT_CTRL1, 8'h00);
    check({bmode, irq}, 16'h0000);
    wr(ASM_ADDR_EXT_CTRL0, 8'h80);
    check(irq, 16'h0001);
    // Clear-to-send masks the flag only; the serial stream keeps going
    cts_cmd = 1'h1;
    tx_raw = 2'h2;
    cyc(2);
    check({tx_e, tx_out}, 16'h000A);
    wr(ASM_ADDR_EXT_CTRL0, 8'h20);
    check(tx_e, 16'h0003);
    wr(ASM_ADDR_EXT_CTRL0, 8'h00);
    c1_sel = 1'h1;
    srx_cmd = 1'h1;
    cyc(1);
    check(tx_e, 16'h0000);
    c1_sel = 1'h0;
    cyc(1);
    check(tx_e, 16'h0002);
    cts_cmd = 1'h0;
    tx_raw = 2'h3;
    rts_ctrl = 1'h1;
    cyc(1);
    check({rts_out, tx_e, rx_f}, 16'h001F);
    err_raw = 1'h1;
    dcd_cmd = 1'h1;
    cyc(1);
    check({rx_f, par_err, frm_err, ov, dcd_bit}, 16'h0021);
    dcd_cmd = 1'h0;
    cyc(2);
    check({rx_f, par_err, frm_err, ov, dcd_bit}, 16'h0021);
    st_rd = 1'h1;
    #1;
    check(dcd_bit, 16'h0001);
    cyc(1);
    st_rd = 1'h0;
    check({rx_f, par_err, frm_err, ov, dcd_bit}, 16'h003E);
    wr(ASM_ADDR_EXT_CTRL0, 8'h40);
    dcd_cmd = 1'h1;
    cyc(1);
    check({rx_f, par_err, frm_err, ov}, 16'h001F);
    wr(ASM_ADDR_EXT_CTRL0, 8'h01);
    cyc(1);
    check(tx_out, 16'h0002);
    wr(ASM_ADDR_EXT_CTRL0, 8'h04);
    line_cmd = 2'h2;
    brk_seen = 2'h1;
    cyc(1);
    brk_seen = 2'h0;
    rd(ASM_ADDR_EXT_CTRL0, 8'h06);
    line_cmd = 2'h3;
    cyc(1);
    rd(ASM_ADDR_EXT_CTRL0, 8'h04);
    wr(ASM_ADDR_EXT_CTRL0, 8'h10);
    // Direct bit clock needs the external pin selected as source
    ext_sel = 2'h1;
    ticks = 0;
    pulse();
    cyc(3);
    check(ticks, 16'h0001);
    // Mid-run reset also clears the sampling counter before the divide test
    rst_n = 1'h0;
    cyc(2);
    check({rts_out, tick, tx_out}, 16'h0003);
    rst_n = 1'h1;
    rd(ASM_ADDR_EXT_CTRL0, 8'h00);
    check(div0, 16'h0000);
    ext_sel = 2'h1;
    ticks = 0;
    repeat (15) pulse();
    cyc(3);
    check(ticks, 16'h0000);
    pulse();
    cyc(3);
    check(ticks, 16'h0001);
    finish_test();
  end

  initial begin
    #20us;
    n_errors++;
    finish_test();
  end
endmodule
